// ===== psfg_cfg.svh
// Purpose: Constants for the power switch fault and power-good logic
// Assumes: 125 MHz block clock
// Notes: Times in microseconds, counts derived from the clock rate
`ifndef PSFG_CFG_SVH
`define PSFG_CFG_SVH
`define PSFG_CLK_MHZ 125
`define PSFG_GOOD_ASSERT_US 10
`define PSFG_GOOD_DEASSERT_US 10
`define PSFG_BLANK_US 1000
`define PSFG_RETRY_US 16000
`define PSFG_GOOD_ASSERT_CYC (`PSFG_GOOD_ASSERT_US * `PSFG_CLK_MHZ)
`define PSFG_GOOD_DEASSERT_CYC (`PSFG_GOOD_DEASSERT_US * `PSFG_CLK_MHZ)
`define PSFG_BLANK_CYC (`PSFG_BLANK_US * `PSFG_CLK_MHZ)
`define PSFG_RETRY_CYC (`PSFG_RETRY_US * `PSFG_CLK_MHZ)
`define PSFG_CNT_W 24
`define PSFG_CTRL_ADDR 8'h00
`define PSFG_STAT_ADDR 8'h04
`define PSFG_CTRL_RESET 8'h01
`define PSFG_CTRL_ENABLE 0
`define PSFG_CTRL_RETRY 1
`define PSFG_CTRL_BREAKER 2
`define PSFG_CTRL_CLAMP 3
`define PSFG_CTRL_FLAGPIN 4
`define PSFG_STAT_STATE 0
`define PSFG_STAT_FAULT 4
`define PSFG_STAT_SWITCH 8
`define PSFG_STAT_GOOD 9
`define PSFG_STAT_FLAG_N 10
`define PSFG_STAT_LIMIT 11
`endif

// ===== psfg_pkg.sv
// Purpose: Types for the power switch fault and power-good logic
// Assumes: Comparator levels already digital
// Notes: Sense struct carries every pin-level input
`default_nettype none
package psfg_pkg;
  typedef struct packed {
    logic enable_undervoltage_input;
    logic en_sd;
    logic supply;
    logic undervoltage_protect;
    logic ovp;
    logic over_temp;
    logic cooled;
    logic over_cur;
    logic short_ckt;
    logic ilm_short;
    logic ilm_open;
    logic good_rise;
    logic good_fall;
    logic gate_full;
  } psfg_sense_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_INRUSH = 3'h1,
    ST_ON = 3'h2,
    ST_LATCHED = 3'h3,
    ST_COOL = 3'h4,
    ST_RETRY = 3'h5
  } psfg_state_t;
  typedef enum logic [2:0] {
    FT_NONE = 3'h0,
    FT_TEMP = 3'h1,
    FT_BREAKER = 3'h2,
    FT_ILM_SHORT = 3'h3
  } psfg_fault_t;
endpackage : psfg_pkg
`default_nettype wire

// ===== psfg_core.sv
// Purpose: Fault response, fault flag and power-good logic of a power switch
// Assumes: Analog comparators deliver levels; Wishbone classic slave
// Notes: Flag and good pins are open-drain: oe high pulls the pin low
`include "psfg_cfg.svh"
`default_nettype none
module psfg_core #(
  parameter int GOOD_ASSERT_CYC = `PSFG_GOOD_ASSERT_CYC,
  parameter int GOOD_DEASSERT_CYC = `PSFG_GOOD_DEASSERT_CYC,
  parameter int BLANK_CYC = `PSFG_BLANK_CYC,
  parameter int RETRY_CYC = `PSFG_RETRY_CYC
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire psfg_pkg::psfg_sense_t sense_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic pass_switch_o,
  output logic limiting_o,
  output logic fault_flag_n_o,
  output logic fault_flag_oe_o,
  output logic power_good_o,
  output logic power_good_oe_o
);
  localparam int CW = `PSFG_CNT_W;

  psfg_pkg::psfg_sense_t meta_r;
  psfg_pkg::psfg_sense_t s_r;
  psfg_pkg::psfg_state_t state_r;
  psfg_pkg::psfg_state_t state_nxt;
  psfg_pkg::psfg_fault_t fault_r;
  logic [7:0] ctrl_r;
  logic [CW-1:0] blank_cnt_r;
  logic [CW-1:0] retry_cnt_r;
  logic [CW-1:0] dg_cnt_r;
  logic blank_done;
  logic retry_done;
  logic run_ok;
  logic clear_req;
  logic ilm_open_r;
  logic pg_level_r;
  logic good_cond;
  logic flag_cond;
  logic cl_active;
  logic power_good_r;
  logic fault_flag_n_r;
  logic limiting_r;
  logic ack_r;
  logic [31:0] rdata_r;

  function automatic logic is_live(input psfg_pkg::psfg_state_t st);
    is_live = (st == psfg_pkg::ST_INRUSH) || (st == psfg_pkg::ST_ON);
  endfunction : is_live

  // Pins are asynchronous to the block clock
  always_ff @(posedge clock_i) begin
    meta_r <= sense_i;
    s_r <= meta_r;
  end

  // Removing supply or enable below shutdown clears a latch
  assign clear_req = !s_r.supply || !s_r.en_sd;
  // Open monitor pin holds the switch off only after its blanking ran out
  assign run_ok = s_r.supply && s_r.enable_undervoltage_input && !s_r.undervoltage_protect && ctrl_r[`PSFG_CTRL_ENABLE]
    && !(s_r.ovp && !ctrl_r[`PSFG_CTRL_CLAMP]) && !ilm_open_r;
  assign blank_done = blank_cnt_r == CW'(BLANK_CYC - 1);
  assign retry_done = retry_cnt_r == CW'(RETRY_CYC - 1);
  assign cl_active = !ctrl_r[`PSFG_CTRL_BREAKER] && s_r.over_cur && blank_done;

  // Blanking counts while any slow current fault persists
  always_ff @(posedge clock_i) begin
    if (!rstn_i || !is_live(state_r)) begin
      blank_cnt_r <= '0;
    end else if (s_r.over_cur || s_r.ilm_short || s_r.ilm_open) begin
      if (!blank_done) begin
        blank_cnt_r <= blank_cnt_r + CW'(1);
      end
    end else begin
      blank_cnt_r <= '0;
    end
  end

  // Retry delay restarts on every entry and on a clear
  always_ff @(posedge clock_i) begin
    if (!rstn_i || state_r != psfg_pkg::ST_RETRY || clear_req) begin
      retry_cnt_r <= '0;
    end else if (!retry_done) begin
      retry_cnt_r <= retry_cnt_r + CW'(1);
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      psfg_pkg::ST_OFF: begin
        if (run_ok) begin
          state_nxt = psfg_pkg::ST_INRUSH;
        end
      end
      psfg_pkg::ST_INRUSH, psfg_pkg::ST_ON: begin
        if (s_r.over_temp) begin
          state_nxt = psfg_pkg::ST_COOL;
        end else if ((s_r.ilm_short || (ctrl_r[`PSFG_CTRL_BREAKER] && s_r.over_cur))
                     && blank_done) begin
          state_nxt = ctrl_r[`PSFG_CTRL_RETRY] ? psfg_pkg::ST_RETRY
                                                : psfg_pkg::ST_LATCHED;
        end else if (s_r.ilm_open && blank_done) begin
          state_nxt = psfg_pkg::ST_OFF;
        end else if (!run_ok) begin
          state_nxt = psfg_pkg::ST_OFF;
        end else if (state_r == psfg_pkg::ST_INRUSH && s_r.gate_full) begin
          state_nxt = psfg_pkg::ST_ON;
        end
      end
      psfg_pkg::ST_COOL: begin
        if (clear_req) begin
          state_nxt = psfg_pkg::ST_OFF;
        end else if (s_r.cooled) begin
          state_nxt = ctrl_r[`PSFG_CTRL_RETRY] ? psfg_pkg::ST_RETRY
                                                : psfg_pkg::ST_LATCHED;
        end
      end
      psfg_pkg::ST_LATCHED: begin
        if (clear_req) begin
          state_nxt = psfg_pkg::ST_OFF;
        end
      end
      psfg_pkg::ST_RETRY: begin
        if (clear_req || retry_done) begin
          state_nxt = psfg_pkg::ST_OFF;
        end
      end
      default: state_nxt = psfg_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_r <= psfg_pkg::ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latch holds the type until a clear or a retry expiry
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      fault_r <= psfg_pkg::FT_NONE;
    end else if (is_live(state_r) && state_nxt == psfg_pkg::ST_COOL) begin
      fault_r <= psfg_pkg::FT_TEMP;
    end else if (is_live(state_r) && !is_live(state_nxt) && state_nxt != psfg_pkg::ST_OFF) begin
      fault_r <= s_r.ilm_short ? psfg_pkg::FT_ILM_SHORT : psfg_pkg::FT_BREAKER;
    end else if (state_nxt == psfg_pkg::ST_OFF) begin
      fault_r <= psfg_pkg::FT_NONE;
    end
  end

  // Open monitor pin: not latched, flagged until the pin recovers
  always_ff @(posedge clock_i) begin
    if (!rstn_i || !s_r.ilm_open) begin
      ilm_open_r <= 1'b0;
    end else if (is_live(state_r) && blank_done) begin
      ilm_open_r <= 1'b1;
    end
  end

  // Breaker trips are never flagged; short circuit never flags
  assign flag_cond = fault_r == psfg_pkg::FT_TEMP || fault_r == psfg_pkg::FT_ILM_SHORT
    || ilm_open_r || (cl_active && state_r == psfg_pkg::ST_ON);

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      fault_flag_n_r <= 1'b1;
      limiting_r <= 1'b0;
    end else begin
      fault_flag_n_r <= !(ctrl_r[`PSFG_CTRL_FLAGPIN] && flag_cond);
      limiting_r <= is_live(state_r) && (cl_active || s_r.short_ckt);
    end
  end

  // Hysteresis between rise and fall thresholds
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      pg_level_r <= 1'b0;
    end else if (s_r.good_rise) begin
      pg_level_r <= 1'b1;
    end else if (!s_r.good_fall) begin
      pg_level_r <= 1'b0;
    end
  end

  // Only the fully on switch counts; inrush keeps good low
  assign good_cond = state_r == psfg_pkg::ST_ON && pg_level_r;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      dg_cnt_r <= '0;
      power_good_r <= 1'b0;
    end else if (good_cond == power_good_r) begin
      dg_cnt_r <= '0;
    end else if (good_cond && dg_cnt_r == CW'(GOOD_ASSERT_CYC - 1)) begin
      power_good_r <= 1'b1;
      dg_cnt_r <= '0;
    end else if (!good_cond && dg_cnt_r == CW'(GOOD_DEASSERT_CYC - 1)) begin
      power_good_r <= 1'b0;
      dg_cnt_r <= '0;
    end else begin
      dg_cnt_r <= dg_cnt_r + CW'(1);
    end
  end

  assign pass_switch_o = is_live(state_r);
  assign limiting_o = limiting_r;
  assign fault_flag_n_o = fault_flag_n_r;
  assign fault_flag_oe_o = !fault_flag_n_r;
  assign power_good_o = power_good_r;
  assign power_good_oe_o = !power_good_r;

  // Wishbone: one wait state, then ack for a single cycle
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
      ctrl_r <= `PSFG_CTRL_RESET;
      rdata_r <= '0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      rdata_r <= '0;
      // Write lands at the edge where the master sees ack
      if (wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0]
          && wb_adr_i == `PSFG_CTRL_ADDR) begin
        ctrl_r <= wb_dat_i[7:0];
      end
      if (wb_cyc_i && wb_stb_i && !ack_r) begin
        if (!wb_we_i && wb_adr_i == `PSFG_CTRL_ADDR) begin
          rdata_r <= {24'h000000, ctrl_r};
        end else if (!wb_we_i && wb_adr_i == `PSFG_STAT_ADDR) begin
          rdata_r[`PSFG_STAT_STATE +: 3] <= state_r;
          rdata_r[`PSFG_STAT_FAULT +: 3] <= fault_r;
          rdata_r[`PSFG_STAT_SWITCH] <= pass_switch_o;
          rdata_r[`PSFG_STAT_GOOD] <= power_good_r;
          rdata_r[`PSFG_STAT_FLAG_N] <= fault_flag_n_r;
          rdata_r[`PSFG_STAT_LIMIT] <= limiting_r;
        end
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  sequence seq_ilm_trip;
    is_live(state_r) && s_r.ilm_short && blank_done && !s_r.over_temp;
  endsequence
  sequence seq_clear;
    state_r == psfg_pkg::ST_LATCHED && clear_req;
  endsequence

  a_uv_shutdown: assert property (@(posedge clock_i) disable iff (!rstn_i)
    is_live(state_r) && (s_r.undervoltage_protect || !s_r.enable_undervoltage_input) && !s_r.over_temp && !blank_done
    |=> !pass_switch_o && fault_r == psfg_pkg::FT_NONE)
    else $error("undervoltage did not shut down cleanly");
  a_transient_pass: assert property (@(posedge clock_i) disable iff (!rstn_i)
    state_r == psfg_pkg::ST_ON && run_ok && !s_r.over_temp && !blank_done
    |=> state_r == psfg_pkg::ST_ON)
    else $error("transient overcurrent caused action");
  a_ilm_latch: assert property (@(posedge clock_i) disable iff (!rstn_i)
    seq_ilm_trip |=> fault_r == psfg_pkg::FT_ILM_SHORT && !pass_switch_o)
    else $error("monitor pin short not latched");
  a_breaker_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
    is_live(state_r) && ctrl_r[`PSFG_CTRL_BREAKER] && s_r.over_cur && blank_done
    && !s_r.over_temp |=> !pass_switch_o ##1 !fault_flag_n_o == 1'b0)
    else $error("breaker did not trip");
  a_clear_release: assert property (@(posedge clock_i) disable iff (!rstn_i)
    seq_clear |=> fault_r == psfg_pkg::FT_NONE ##1 fault_flag_n_o)
    else $error("clear did not release flag");
  a_latch_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
    state_r == psfg_pkg::ST_LATCHED && !clear_req |=> state_r == psfg_pkg::ST_LATCHED)
    else $error("latched fault left without clear");
  a_retry_end: assert property (@(posedge clock_i) disable iff (!rstn_i)
    state_r == psfg_pkg::ST_RETRY && retry_done |=> state_r == psfg_pkg::ST_OFF
    && fault_r == psfg_pkg::FT_NONE)
    else $error("retry expiry did not restart");
  a_good_rise: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(power_good_r) |-> $past(good_cond) && $past(dg_cnt_r) == CW'(GOOD_ASSERT_CYC - 1))
    else $error("power-good rose without deglitch");
  a_good_fall: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $fell(power_good_r) |-> !$past(good_cond)
    && $past(dg_cnt_r) == CW'(GOOD_DEASSERT_CYC - 1))
    else $error("power-good fell without deglitch");
  a_inrush_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(power_good_r) |-> $past(state_r) == psfg_pkg::ST_ON)
    else $error("power-good rose outside on state");
endmodule : psfg_core
`default_nettype wire

// ===== psfg_ctrl_model.sv
// Purpose: System controller model that drives the enable input
// Assumes: Bench picks the enable phase through mode_i
// Notes: Reads the open-drain flag and good pins through pull-ups
`default_nettype none
module psfg_ctrl_model (
  input wire logic clock_i,
  input wire logic [1:0] mode_i,
  input wire logic flag_pin_i,
  input wire logic good_pin_i,
  output logic enable_undervoltage_input_o,
  output logic en_sd_o,
  output logic alarm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode 1 only dips below undervoltage, mode 2 goes below shutdown
  always @(posedge clock_i) begin
    enable_undervoltage_input_o <= (mode_i == 2'h0);
    en_sd_o <= (mode_i != 2'h2);
    alarm_o <= !flag_pin_i || !good_pin_i;
  end
endmodule : psfg_ctrl_model
`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the fault and power-good logic
// Assumes: Short parameter values keep every count small
// Notes: Pin levels rebuilt from open-drain enables and pull-ups
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GA = 4;
  localparam int GD = 4;
  localparam int BL = 8;
  localparam int RT = 16;
  logic clock_i, rstn_i, cyc, stb, we, ack, sw, lim, fl_n, fl_oe, pg, pg_oe, enable_undervoltage_input, en_sd;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [1:0] mode;
  psfg_pkg::psfg_sense_t sense_r, sense_w;
  int error_cnt = 0;
  int compares = 0;
  int cyc_cnt = 0;
  wire flag_pin = fl_oe ? 1'b0 : 1'b1;
  wire good_pin = pg_oe ? 1'b0 : 1'b1;
  always_comb begin
    sense_w = sense_r;
    sense_w.enable_undervoltage_input = enable_undervoltage_input;
    sense_w.en_sd = en_sd;
  end
  psfg_core #(.GOOD_ASSERT_CYC(GA), .GOOD_DEASSERT_CYC(GD), .BLANK_CYC(BL),
    .RETRY_CYC(RT)) psfg_core_inst (.clock_i(clock_i), .rstn_i(rstn_i),
    .sense_i(sense_w), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pass_switch_o(sw), .limiting_o(lim), .fault_flag_n_o(fl_n),
    .fault_flag_oe_o(fl_oe), .power_good_o(pg), .power_good_oe_o(pg_oe));
  psfg_ctrl_model psfg_ctrl_model_inst (.clock_i(clock_i), .mode_i(mode),
    .flag_pin_i(flag_pin), .good_pin_i(good_pin), .enable_undervoltage_input_o(enable_undervoltage_input),
    .en_sd_o(en_sd), .alarm_o());
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : wait_cyc
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk("wb ack", 32'h0, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Status fields, switch, good and flag pins in one go
  task automatic st(input logic [2:0] f, input logic s, input logic g, input logic n);
    wb(1'b0, 8'h04, 32'h0);
    chk("status", q & 32'h0000_0770, {21'h0, n, g, s, 1'b0, f, 4'h0});
    chk("switch", {31'h0, sw}, {31'h0, s});
    chk("good pin", {31'h0, good_pin}, {31'h0, g});
    chk("flag pin", {31'h0, flag_pin}, {31'h0, n});
  endtask : st
  task automatic t_reset;
    chk("flag idle", {31'h0, flag_pin}, 32'h1);
    chk("good idle", {31'h0, good_pin}, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", q, 32'h01);
    wb(1'b1, 8'h08, 32'hff);
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask : t_reset
  task automatic t_power;
    wb(1'b1, 8'h00, 32'h11);
    wait_cyc(20);
    st(3'h0, 1'b1, 1'b0, 1'b1);
    sense_r.gate_full <= 1'b1;
    wait_cyc(GA + 1);
    chk("good early", {31'h0, good_pin}, 32'h0);
    wait_cyc(GA + 8);
    st(3'h0, 1'b1, 1'b1, 1'b1);
  endtask : t_power
  // Overcurrent shorter than the blanking timer, then a brief output short
  task automatic t_glitch;
    sense_r.over_cur <= 1'b1;
    wait_cyc(BL - 2);
    sense_r.over_cur <= 1'b0;
    sense_r.short_ckt <= 1'b1;
    wait_cyc(4);
    chk("limit on", {31'h0, lim}, 32'h1);
    sense_r.short_ckt <= 1'b0;
    wait_cyc(20);
    st(3'h0, 1'b1, 1'b1, 1'b1);
    chk("limit off", {31'h0, lim}, 32'h0);
    // Persistent overload in current-limit mode flags but keeps good
    sense_r.over_cur <= 1'b1;
    wait_cyc(BL + 6);
    chk("limit flag", {31'h0, flag_pin}, 32'h0);
    chk("limit held", {31'h0, lim}, 32'h1);
    chk("good in limit", {31'h0, good_pin}, 32'h1);
    sense_r.over_cur <= 1'b0;
    wait_cyc(6);
    chk("limit flag off", {31'h0, flag_pin}, 32'h1);
  endtask : t_glitch
  task automatic t_drop;
    sense_r.good_rise <= 1'b0;
    sense_r.good_fall <= 1'b0;
    wait_cyc(GD);
    chk("good held", {31'h0, good_pin}, 32'h1);
    wait_cyc(10);
    chk("good fell", {31'h0, good_pin}, 32'h0);
    sense_r.good_rise <= 1'b1;
    sense_r.good_fall <= 1'b1;
    wait_cyc(GA + 10);
    st(3'h0, 1'b1, 1'b1, 1'b1);
  endtask : t_drop
  task automatic t_uvp;
    sense_r.undervoltage_protect <= 1'b1;
    wait_cyc(GD + 10);
    st(3'h0, 1'b0, 1'b0, 1'b1);
    sense_r.undervoltage_protect <= 1'b0;
    wait_cyc(GA + 20);
    st(3'h0, 1'b1, 1'b1, 1'b1);
    sense_r.ovp <= 1'b1;
    wait_cyc(GD + 10);
    st(3'h0, 1'b0, 1'b0, 1'b1);
    sense_r.ovp <= 1'b0;
    wait_cyc(GA + 20);
    st(3'h0, 1'b1, 1'b1, 1'b1);
  endtask : t_uvp
  task automatic t_ilm;
    sense_r.ilm_short <= 1'b1;
    wait_cyc(BL);
    chk("flag blanked", {31'h0, flag_pin}, 32'h1);
    wait_cyc(GD + 10);
    st(3'h3, 1'b0, 1'b0, 1'b0);
    sense_r.ilm_short <= 1'b0;
    mode <= 2'h1;
    wait_cyc(10);
    st(3'h3, 1'b0, 1'b0, 1'b0);
    mode <= 2'h2;
    wait_cyc(10);
    st(3'h0, 1'b0, 1'b0, 1'b1);
    mode <= 2'h0;
    wait_cyc(GA + 20);
    st(3'h0, 1'b1, 1'b1, 1'b1);
  endtask : t_ilm
  // Open monitor pin: off and flagged, not latched, recovers by itself
  task automatic t_open;
    sense_r.ilm_open <= 1'b1;
    wait_cyc(BL);
    chk("open blanked", {31'h0, flag_pin}, 32'h1);
    wait_cyc(GD + 10);
    st(3'h0, 1'b0, 1'b0, 1'b0);
    sense_r.ilm_open <= 1'b0;
    wait_cyc(GA + 20);
    st(3'h0, 1'b1, 1'b1, 1'b1);
  endtask : t_open
  // Breaker variant with auto-retry; flag pin left released here
  task automatic t_break;
    wb(1'b1, 8'h00, 32'h07);
    sense_r.over_cur <= 1'b1;
    wait_cyc(BL + GD + 4);
    sense_r.over_cur <= 1'b0;
    st(3'h2, 1'b0, 1'b0, 1'b1);
    wait_cyc(RT + GA + 20);
    st(3'h0, 1'b1, 1'b1, 1'b1);
  endtask : t_break
  task automatic t_temp;
    wb(1'b1, 8'h00, 32'h13);
    sense_r.over_temp <= 1'b1;
    wait_cyc(GD + 10);
    st(3'h1, 1'b0, 1'b0, 1'b0);
    sense_r.over_temp <= 1'b0;
    sense_r.cooled <= 1'b1;
    wait_cyc(RT + GA + 20);
    st(3'h0, 1'b1, 1'b1, 1'b1);
  endtask : t_temp
  initial begin
    rstn_i = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    mode = 2'h0;
    sense_r = '0;
    sense_r.supply = 1'b1;
    sense_r.good_rise = 1'b1;
    sense_r.good_fall = 1'b1;
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_reset();
    t_power();
    t_glitch();
    t_drop();
    t_uvp();
    t_ilm();
    t_open();
    t_break();
    t_temp();
    results();
  end
endmodule : tb_top
`default_nettype wire
